// >>> design/cycle_framer.sv
// Framer: synchronises bus pins and turns a chip-select frame into a cycle
module cycle_framer
    import cmd_decode_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        cs_n,
    input  wire logic        cycle_strobe,
    input  wire logic [47:0] ca,
    input  wire logic [15:0] wdata,
    cycle_if.src             cyc
);
    typedef struct packed {
        logic [1:0]  cs_s;
        logic [1:0]  stb_s;
        logic        stb_prev;
        logic        valid;
        logic        is_write;
        logic        is_read;
        logic [44:0] addr;
        logic [15:0] data;
        logic        frame_end;
    } framer_s;
    framer_s st_q;
    framer_s st_d;
    logic [47:0] ca_s1_q;
    logic [47:0] ca_s2_q;
    logic [15:0] wd_s1_q;
    logic [15:0] wd_s2_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ca_s1_q <= '0;
            ca_s2_q <= '0;
            wd_s1_q <= '0;
            wd_s2_q <= '0;
        end else begin
            ca_s1_q <= ca;
            ca_s2_q <= ca_s1_q;
            wd_s1_q <= wdata;
            wd_s2_q <= wd_s1_q;
        end
    end

    always_comb begin
        st_d = st_q;
        st_d.cs_s = {st_q.cs_s[0], cs_n};
        st_d.stb_s = {st_q.stb_s[0], cycle_strobe};
        st_d.stb_prev = st_q.stb_s[1];
        st_d.valid = 1'b0;
        st_d.frame_end = st_q.cs_s[1] && (st_q.stb_s[1] == st_q.stb_prev);
        // Pins are held stable by the host while the strobe is high
        if (st_q.stb_s[1] && !st_q.stb_prev && !st_q.cs_s[1]) begin
            st_d.valid = 1'b1;
            st_d.is_write = ca_s2_q[47:45] == CA_TOP_WRITE;
            st_d.is_read = ca_s2_q[47:45] == CA_TOP_READ;
            st_d.addr = ca_s2_q[44:0];
            st_d.data = wd_s2_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{cs_s: 2'h3, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign cyc.valid = st_q.valid;
    assign cyc.is_write = st_q.is_write;
    assign cyc.is_read = st_q.is_read;
    assign cyc.addr = st_q.addr;
    assign cyc.data = st_q.data;
    assign cyc.frame_end = st_q.frame_end;
endmodule // cycle_framer

// >>> design/flash_overlay_command_decoder.sv
// Command-sequence decoder for overlay and suspend commands
// Summary of operation
// [R1] Write of 51h anywhere requests program suspend; the code flags 51h as illegal in the ECC overlay.
// [R2] Write of 50h anywhere resumes suspended programming; the code resumes only when no overlay is active.
// [R3] AAh@555, 55h@2AA, 90h@555 enters identification overlay.
// [R4] Single 98h@555 also enters identification overlay.
// [R5] Top bits 001b mark writes, 101b reads; reads return 16-bit word.
// [R6] F0h write at any address leaves the current overlay.
// [R7] Unlock then 88h at sector address enters secure overlay.
// [R8] Unlock, A0h@555, then address with data programs a secure word.
// [R9] Unlock, 25h, count, address/data pairs, then 29h buffered program.
// [R10] Unlock then F0h recovers from aborted buffered program.
// [R11] Unlock+40h enters config overlay; A0h then data programs word.
// [R12] Unlock+60h enters password overlay; A0h then indexed word program.
// [R13] Unlock: 25h, 03h, four words indices 0..3, confirm at index 0.
// [R14] Unlock+C0h persistent overlay; A0h,00h protects; 80h,30h@000 erases.
// [R15] In protection overlay 60h then read gives sector status word.
// [R16] Unlock+50h lock overlay; A0h then 00h clears lock bit; read it.
// [R17] Unlock+E0h volatile overlay; A0h,00h sets, A0h,01h clears.
// [R18] Unlock+75h ECC overlay; 60h then index read gives ECC details.
// [R19] In ECC overlay a 50h write clears ECC error information.
// [R20] Unlock+76h interface CRC overlay; index reads return halves.
// [R21] Unlock+78h array CRC overlay; C3h/3Ch load start and end.
// [R22] C0 suspends and C1 resumes array CRC calculation.
// [R23] Unlock then 14h@555 enters boot configuration overlay.
// [R24] Host must exit an overlay before normal array reads resume.
// [R25] Command addresses are 16-bit word addresses.
// [R26] Die-select bits must be 00b in every cycle.
// [R27] Illegal sequence returns to standby when chip select rises.
// [R28] Sequence matching restarts on any mismatched address or data.
module flash_overlay_command_decoder
    import cmd_decode_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    input  wire logic        CS_N,
    input  wire logic        CYCLE_STROBE,
    input  wire logic [47:0] CA,
    input  wire logic [15:0] WDATA,
    input  wire logic [15:0] OVERLAY_RDATA,
    input  wire logic        CRC_BUSY,
    output logic      [15:0] RDATA,
    output logic             RDATA_VALID,
    output logic      [12:0] OVERLAY,
    output logic      [44:0] CMD_ADDR,
    output logic      [15:0] CMD_DATA,
    output logic             READ_REQ,
    output logic             STATUS_READ,
    output logic             PROG_SUSPEND,
    output logic             PROG_RESUME,
    output logic             WORD_PROGRAM,
    output logic             BUF_LOAD,
    output logic             BUF_CONFIRM,
    output logic             ABORT_RESET,
    output logic             PASSWORD_UNLOCK,
    output logic             SECTOR_ERASE_ALL,
    output logic             ECC_CLEAR,
    output logic             CRC_START_LOAD,
    output logic             CRC_END_LOAD,
    output logic             CRC_SUSPEND,
    output logic             CRC_RESUME
);
    cycle_if cyc ();

    cycle_framer u_framer (
        .clk          (SYS_CLK),
        .rst_n        (RST_N),
        .cs_n         (CS_N),
        .cycle_strobe (CYCLE_STROBE),
        .ca           (CA),
        .wdata        (WDATA),
        .cyc          (cyc)
    );

    typedef struct packed {
        overlay_e    ov;
        seq_e        seq;
        logic [7:0]  third;
        logic [8:0]  words_left;
        logic [1:0]  pw_idx;
        logic        illegal;
        logic [44:0] addr;
        logic [15:0] data;
        logic        read_req;
        logic        status_read;
        logic [15:0] rdata;
        logic        rvalid;
        logic [12:0] pulses;
    } dec_s;
    dec_s st_q;
    dec_s st_d;

    logic [11:0] word_off;
    logic [7:0]  cmd;
    logic        die_ok;
    logic        wr;
    logic        rd;
    logic        in_prot;

    assign word_off = cyc.addr[11:0]; // [R25]
    assign cmd = cyc.data[7:0];
    assign die_ok = cyc.addr[44:43] == DIE_SELECT_VAL; // [R26]
    assign wr = cyc.valid && cyc.is_write && die_ok; // [R5]
    assign rd = cyc.valid && cyc.is_read && die_ok; // [R5]
    assign in_prot = st_q.ov inside {OV_PERS, OV_VOL};

    // Pulse bit order matches the pulse outputs below
    localparam int P_SUSP = 0, P_RES = 1, P_WPROG = 2, P_BLOAD = 3;
    localparam int P_BCONF = 4, P_ABORT = 5, P_PWUNL = 6, P_ERALL = 7;
    localparam int P_ECLR = 8, P_CSTA = 9, P_CEND = 10, P_CSUS = 11;
    localparam int P_CRES = 12;

    always_comb begin
        st_d = st_q;
        st_d.pulses = '0;
        st_d.read_req = 1'b0;
        st_d.status_read = 1'b0;
        st_d.rvalid = 1'b0;
        if (cyc.valid) begin
            st_d.addr = cyc.addr;
            st_d.data = cyc.data;
        end
        if (cyc.valid && !(wr || rd)) begin
            st_d.illegal = 1'b1;
            st_d.seq = SQ_IDLE;
        end
        if (rd) begin
            st_d.read_req = 1'b1; // [R5]
            st_d.status_read = st_q.seq == SQ_STAT; // [R15] [R18] [R21]
            st_d.seq = SQ_IDLE;
        end
        if (wr) begin
            st_d.seq = SQ_IDLE; // [R28]
            unique case (st_q.seq)
                SQ_IDLE: begin
                    if (cmd == CMD_UNLOCK1 && word_off == ADDR_555) begin
                        st_d.seq = SQ_UNL1; // [R3]
                    end else if (cmd == CMD_EXIT && st_q.ov != OV_NONE) begin
                        st_d.ov = OV_NONE; // [R6]
                    end else if (cmd == CMD_IDENT_ALT && word_off == ADDR_555
                                 && st_q.ov == OV_NONE) begin
                        st_d.ov = OV_IDENT; // [R4]
                    end else if (cmd == CMD_PROGRAM && st_q.ov != OV_NONE) begin
                        st_d.seq = SQ_ARG; // [R11] [R12] [R14] [R16] [R17]
                        st_d.third = CMD_PROGRAM;
                    end else if (cmd == CMD_ERASE_SETUP && st_q.ov == OV_PERS) begin
                        st_d.seq = SQ_ERASE; // [R14]
                    end else if (cmd == CMD_STATUS && (in_prot ||
                                 st_q.ov inside {OV_ECC, OV_ARCRC})) begin
                        st_d.seq = SQ_STAT; // [R15] [R18] [R21]
                    end else if (cmd == CMD_BUFFER && st_q.ov == OV_PASS
                                 && cyc.addr[1:0] == 2'h0) begin
                        st_d.seq = SQ_PWKEY; // [R13]
                    end else if (cmd == CMD_CONFIRM && st_q.ov == OV_SECURE) begin
                        st_d.pulses[P_BCONF] = 1'b1; // [R9]
                    end else if (cmd == CMD_ECC_CLEAR && st_q.ov == OV_ECC) begin
                        st_d.pulses[P_ECLR] = 1'b1; // [R19]
                    end else if (st_q.ov == OV_ARCRC && cmd == CMD_CRC_START) begin
                        st_d.pulses[P_CSTA] = 1'b1; // [R21]
                    end else if (st_q.ov == OV_ARCRC && cmd == CMD_CRC_END) begin
                        st_d.pulses[P_CEND] = 1'b1; // [R21]
                    end else if (st_q.ov == OV_ARCRC && CRC_BUSY
                                 && cmd == CMD_CRC_SUSP) begin
                        st_d.pulses[P_CSUS] = 1'b1; // [R22]
                    end else if (st_q.ov == OV_ARCRC && cmd == CMD_CRC_RES) begin
                        st_d.pulses[P_CRES] = 1'b1; // [R22]
                    end else if (cmd == CMD_SUSPEND && st_q.ov != OV_ECC) begin
                        st_d.pulses[P_SUSP] = 1'b1; // [R1]
                    end else if (cmd == CMD_RESUME && st_q.ov == OV_NONE) begin
                        st_d.pulses[P_RES] = 1'b1; // [R2]
                    end else begin
                        st_d.illegal = 1'b1; // [R27]
                    end
                end
                SQ_UNL1: begin
                    if (cmd == CMD_UNLOCK2 && word_off == ADDR_2AA) begin
                        st_d.seq = SQ_UNL2; // [R3]
                    end else begin
                        st_d.illegal = 1'b1; // [R28]
                    end
                end
                SQ_UNL2: begin
                    if (cmd == CMD_EXIT) begin
                        st_d.pulses[P_ABORT] = 1'b1; // [R10]
                    end else if (cmd == CMD_SECURE) begin
                        st_d.ov = OV_SECURE; // [R7]
                    end else if (cmd == CMD_BUFFER && st_q.ov == OV_SECURE) begin
                        st_d.seq = SQ_WCOUNT; // [R9]
                    end else if (word_off != ADDR_555) begin
                        st_d.illegal = 1'b1;
                    end else if (cmd == CMD_PROGRAM && st_q.ov == OV_SECURE) begin
                        st_d.seq = SQ_ARG; // [R8]
                        st_d.third = CMD_SECURE;
                    end else begin
                        unique case (cmd)
                            CMD_IDENT:    st_d.ov = OV_IDENT; // [R3]
                            CMD_PROTCFG:  st_d.ov = OV_PROT; // [R11]
                            CMD_PASSWORD: st_d.ov = OV_PASS; // [R12]
                            CMD_PERSIST:  st_d.ov = OV_PERS; // [R14]
                            CMD_LOCKBIT:  st_d.ov = OV_LOCK; // [R16]
                            CMD_VOLATILE: st_d.ov = OV_VOL; // [R17]
                            CMD_ECC:      st_d.ov = OV_ECC; // [R18]
                            CMD_IF_CRC:   st_d.ov = OV_IFCRC; // [R20]
                            CMD_ARR_CRC:  st_d.ov = OV_ARCRC; // [R21]
                            CMD_BOOT:     st_d.ov = OV_BOOT; // [R23]
                            default:      st_d.illegal = 1'b1;
                        endcase
                    end
                end
                SQ_ARG: begin
                    // Data checks for bit programming overlays
                    if ((st_q.ov inside {OV_PERS, OV_LOCK} && cmd != DATA_ZERO)
                        || (st_q.ov == OV_VOL && cmd != DATA_ZERO
                            && cmd != DATA_ONE)) begin
                        st_d.illegal = 1'b1; // [R14] [R16] [R17]
                    end else begin
                        st_d.pulses[P_WPROG] = 1'b1; // [R8] [R11] [R12]
                    end
                end
                SQ_ERASE: begin
                    if (cmd == CMD_ERASE_GO && word_off == ADDR_000) begin
                        st_d.pulses[P_ERALL] = 1'b1; // [R14]
                    end else begin
                        st_d.illegal = 1'b1;
                    end
                end
                SQ_STAT: begin
                    st_d.illegal = 1'b1;
                end
                SQ_WCOUNT: begin
                    st_d.words_left = {1'b0, cyc.data[7:0]} + 9'h001; // [R9]
                    st_d.seq = SQ_BUFDAT;
                end
                SQ_BUFDAT: begin
                    st_d.pulses[P_BLOAD] = 1'b1; // [R9]
                    st_d.words_left = st_q.words_left - 9'h001;
                    if (st_q.words_left != 9'h001) begin
                        st_d.seq = SQ_BUFDAT;
                    end
                end
                SQ_PWKEY: begin
                    if (cmd == CMD_PW_KEY && cyc.addr[1:0] == 2'h0) begin
                        st_d.seq = SQ_PWWORD; // [R13]
                        st_d.pw_idx = 2'h0;
                        // Drop a confirm flag left by an aborted unlock
                        st_d.third = 8'h00;
                    end else begin
                        st_d.illegal = 1'b1;
                    end
                end
                SQ_PWWORD: begin
                    if (cyc.addr[1:0] != st_q.pw_idx) begin
                        st_d.illegal = 1'b1; // [R13]
                    end else if (st_q.pw_idx == 2'h3) begin
                        st_d.seq = SQ_PWWORD;
                        st_d.pw_idx = 2'h0;
                        st_d.third = CMD_CONFIRM;
                    end else if (st_q.third == CMD_CONFIRM) begin
                        st_d.pulses[P_PWUNL] = 1'b1; // [R13]
                        st_d.third = 8'h00;
                    end else begin
                        st_d.seq = SQ_PWWORD;
                        st_d.pw_idx = st_q.pw_idx + 2'h1;
                    end
                end
                default: st_d.seq = SQ_IDLE;
            endcase
        end
        if (cyc.frame_end && st_q.illegal) begin
            st_d.illegal = 1'b0; // [R27]
            st_d.seq = SQ_IDLE;
        end
        if (st_q.read_req) begin
            st_d.rdata = OVERLAY_RDATA; // [R5]
            st_d.rvalid = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= '{ov: OV_NONE, seq: SQ_IDLE, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign OVERLAY = st_q.ov; // [R24]
    assign CMD_ADDR = st_q.addr;
    assign CMD_DATA = st_q.data;
    assign READ_REQ = st_q.read_req;
    assign STATUS_READ = st_q.status_read;
    assign RDATA = st_q.rdata;
    assign RDATA_VALID = st_q.rvalid;
    assign PROG_SUSPEND = st_q.pulses[P_SUSP];
    assign PROG_RESUME = st_q.pulses[P_RES];
    assign WORD_PROGRAM = st_q.pulses[P_WPROG];
    assign BUF_LOAD = st_q.pulses[P_BLOAD];
    assign BUF_CONFIRM = st_q.pulses[P_BCONF];
    assign ABORT_RESET = st_q.pulses[P_ABORT];
    assign PASSWORD_UNLOCK = st_q.pulses[P_PWUNL];
    assign SECTOR_ERASE_ALL = st_q.pulses[P_ERALL];
    assign ECC_CLEAR = st_q.pulses[P_ECLR];
    assign CRC_START_LOAD = st_q.pulses[P_CSTA];
    assign CRC_END_LOAD = st_q.pulses[P_CEND];
    assign CRC_SUSPEND = st_q.pulses[P_CSUS];
    assign CRC_RESUME = st_q.pulses[P_CRES];

    a_exit_overlay: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        wr && cmd == CMD_EXIT && st_q.seq == SQ_IDLE && st_q.ov != OV_NONE
        |=> st_q.ov == OV_NONE) else $error("exit did not leave overlay"); // [R6]
    a_ident_alt: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        wr && cmd == CMD_IDENT_ALT && word_off == ADDR_555
        && st_q.seq == SQ_IDLE && st_q.ov == OV_NONE
        |=> st_q.ov == OV_IDENT) else $error("98h entry missed"); // [R4]
    a_unlock_step: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        wr && st_q.seq == SQ_IDLE && cmd == CMD_UNLOCK1 && word_off == ADDR_555
        |=> st_q.seq == SQ_UNL1) else $error("first unlock missed"); // [R3]
    a_unlock_restart: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        wr && st_q.seq == SQ_UNL1 && word_off != ADDR_2AA
        |=> st_q.seq == SQ_IDLE) else $error("mismatch kept seq"); // [R28]
    a_suspend_pulse: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        PROG_SUSPEND |-> $past(cmd) == CMD_SUSPEND
        ##1 !PROG_SUSPEND) else $error("suspend pulse wrong"); // [R1]
    a_read_answer: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        rd |-> ##2 RDATA_VALID) else $error("read not answered"); // [R5]
    a_die_select: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        cyc.valid && cyc.addr[44:43] != DIE_SELECT_VAL
        |=> !READ_REQ && $stable(st_q.ov)) else $error("die select ignored"); // [R26]
    a_illegal_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        cyc.frame_end && st_q.illegal && !wr
        |=> st_q.seq == SQ_IDLE && !st_q.illegal) else $error("no standby"); // [R27]
    a_ecc_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        ECC_CLEAR |-> st_q.ov == OV_ECC) else $error("ecc clear outside"); // [R19]
endmodule // flash_overlay_command_decoder

// >>> include/cmd_decode_pkg.sv
// Package: command codes, addresses, overlay and sequence encodings
package cmd_decode_pkg;
    localparam logic [2:0]  CA_TOP_WRITE    = 3'h1;
    localparam logic [2:0]  CA_TOP_READ     = 3'h5;
    localparam logic [1:0]  DIE_SELECT_VAL  = 2'h0;
    localparam logic [11:0] ADDR_555        = 12'h555;
    localparam logic [11:0] ADDR_2AA        = 12'h2AA;
    localparam logic [11:0] ADDR_000        = 12'h000;
    localparam logic [7:0]  CMD_UNLOCK1     = 8'hAA;
    localparam logic [7:0]  CMD_UNLOCK2     = 8'h55;
    localparam logic [7:0]  CMD_SUSPEND     = 8'h51;
    localparam logic [7:0]  CMD_RESUME      = 8'h50;
    localparam logic [7:0]  CMD_IDENT       = 8'h90;
    localparam logic [7:0]  CMD_IDENT_ALT   = 8'h98;
    localparam logic [7:0]  CMD_EXIT        = 8'hF0;
    localparam logic [7:0]  CMD_SECURE      = 8'h88;
    localparam logic [7:0]  CMD_PROGRAM     = 8'hA0;
    localparam logic [7:0]  CMD_BUFFER      = 8'h25;
    localparam logic [7:0]  CMD_CONFIRM     = 8'h29;
    localparam logic [7:0]  CMD_PW_KEY      = 8'h03;
    localparam logic [7:0]  CMD_PROTCFG     = 8'h40;
    localparam logic [7:0]  CMD_PASSWORD    = 8'h60;
    localparam logic [7:0]  CMD_STATUS      = 8'h60;
    localparam logic [7:0]  CMD_PERSIST     = 8'hC0;
    localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0]  CMD_ERASE_GO    = 8'h30;
    localparam logic [7:0]  CMD_LOCKBIT     = 8'h50;
    localparam logic [7:0]  CMD_VOLATILE    = 8'hE0;
    localparam logic [7:0]  DATA_ZERO       = 8'h00;
    localparam logic [7:0]  DATA_ONE        = 8'h01;
    localparam logic [7:0]  CMD_ECC         = 8'h75;
    localparam logic [7:0]  CMD_ECC_CLEAR   = 8'h50;
    localparam logic [7:0]  CMD_IF_CRC      = 8'h76;
    localparam logic [7:0]  CMD_ARR_CRC     = 8'h78;
    localparam logic [7:0]  CMD_CRC_START   = 8'hC3;
    localparam logic [7:0]  CMD_CRC_END     = 8'h3C;
    localparam logic [7:0]  CMD_CRC_SUSP    = 8'hC0;
    localparam logic [7:0]  CMD_CRC_RES     = 8'hC1;
    localparam logic [7:0]  CMD_BOOT        = 8'h14;
    localparam int          ADDR_W          = 45;
    typedef enum logic [12:0] {
        OV_NONE   = 13'h0001, OV_IDENT  = 13'h0002, OV_SECURE = 13'h0004,
        OV_PROT   = 13'h0008, OV_PASS   = 13'h0010, OV_PERS   = 13'h0020,
        OV_LOCK   = 13'h0040, OV_VOL    = 13'h0080, OV_ECC    = 13'h0100,
        OV_IFCRC  = 13'h0200, OV_ARCRC  = 13'h0400, OV_BOOT   = 13'h0800,
        OV_RSVD   = 13'h1000
    } overlay_e;
    typedef enum logic [9:0] {
        SQ_IDLE   = 10'h001, SQ_UNL1   = 10'h002, SQ_UNL2  = 10'h004,
        SQ_ARG    = 10'h008, SQ_ERASE  = 10'h010, SQ_STAT  = 10'h020,
        SQ_WCOUNT = 10'h040, SQ_BUFDAT = 10'h080, SQ_PWKEY = 10'h100,
        SQ_PWWORD = 10'h200
    } seq_e;
endpackage

// >>> include/cycle_if.sv
// Interface: one decoded bus cycle passed from the framer to the decoder
interface cycle_if;
    logic        valid;
    logic        is_write;
    logic        is_read;
    logic [44:0] addr;
    logic [15:0] data;
    logic        frame_end;
    modport src (output valid, is_write, is_read, addr, data, frame_end);
    modport dst (input  valid, is_write, is_read, addr, data, frame_end);
endinterface

// >>> tb/flash_overlay_command_decoder_tb.sv
// Testbench: overlay command decoder driven by a host model
module flash_overlay_command_decoder_tb
    import cmd_decode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, crc_busy, rdv, cs_n, stb;
    logic [15:0] rd_seen, rdata, wd;
    logic [13:0] seen;
    logic [12:0] ovl;
    logic [44:0] cadr;
    logic [47:0] ca;
    wire  [13:0] pv;
    int          errors, total_checks, cycles;
    flash_overlay_command_decoder u_flash_overlay_command_decoder (
        .SYS_CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .CYCLE_STROBE(stb),
        .CA(ca), .WDATA(wd), .OVERLAY_RDATA({cadr[7:0], 8'h3C}),
        .CRC_BUSY(crc_busy), .RDATA(rdata), .RDATA_VALID(rdv),
        .OVERLAY(ovl), .CMD_ADDR(cadr), .CMD_DATA(), .READ_REQ(),
        .STATUS_READ(pv[0]), .PROG_SUSPEND(pv[13]), .PROG_RESUME(pv[12]),
        .WORD_PROGRAM(pv[11]), .BUF_LOAD(pv[10]), .BUF_CONFIRM(pv[9]),
        .ABORT_RESET(pv[8]), .PASSWORD_UNLOCK(pv[7]),
        .SECTOR_ERASE_ALL(pv[6]), .ECC_CLEAR(pv[5]),
        .CRC_START_LOAD(pv[4]), .CRC_END_LOAD(pv[3]),
        .CRC_SUSPEND(pv[2]), .CRC_RESUME(pv[1]));
    host_ctrl_model u_host_ctrl_model (.SYS_CLK(clk), .CS_N(cs_n),
        .CYCLE_STROBE(stb), .CA(ca), .WDATA(wd));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Pulses are gathered between checks
    always @(posedge clk) begin
        seen <= seen | pv;
        if (rdv === 1'b1) rd_seen <= rdata;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp_v(input string n, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cmp_ov(input overlay_e e);
        total_checks++;
        if (ovl !== e) begin
            errors++;
            $display("MISMATCH overlay exp %h got %h", e, ovl);
        end
    endtask
    task automatic pchk(input logic [13:0] e);
        cmp_v("pulses", {2'h0, e}, {2'h0, seen});
        seen = 14'h0;
    endtask
    task automatic w(input logic [11:0] a, input logic [7:0] d);
        u_host_ctrl_model.cyc(1'b0, a, {8'h00, d});
    endtask
    task automatic unl(input logic [7:0] d);
        w(ADDR_555, CMD_UNLOCK1);
        w(ADDR_2AA, CMD_UNLOCK2);
        w(ADDR_555, d);
    endtask
    task automatic sc_ident();
        w(12'h7A1, CMD_SUSPEND);
        pchk(14'h2000);
        w(12'h0F3, CMD_RESUME);
        pchk(14'h1000);
        w(ADDR_555, CMD_IDENT_ALT);
        cmp_ov(OV_IDENT);
        u_host_ctrl_model.cyc(1'b1, 12'h0A6, 16'h0);
        cmp_v("rdata", 16'hA63C, rd_seen);
        w(12'h000, CMD_EXIT);
        w(ADDR_555, CMD_UNLOCK1);
        w(12'h2AB, CMD_UNLOCK2);
        w(ADDR_555, CMD_IDENT);
        cmp_ov(OV_NONE);
    endtask
    task automatic sc_entry();
        logic [7:0] c [10] = '{8'h90, 8'h40, 8'h60, 8'hC0, 8'h50, 8'hE0,
                               8'h75, 8'h76, 8'h78, 8'h14};
        overlay_e o [10] = '{OV_IDENT, OV_PROT, OV_PASS, OV_PERS, OV_LOCK,
                             OV_VOL, OV_ECC, OV_IFCRC, OV_ARCRC, OV_BOOT};
        for (int i = 0; i < 10; i++) begin
            unl(c[i]);
            cmp_ov(o[i]);
            w(12'h3C4, CMD_EXIT);
            cmp_ov(OV_NONE);
        end
    endtask
    task automatic sc_ops();
        unl(CMD_SECURE);
        cmp_ov(OV_SECURE);
        unl(CMD_PROGRAM);
        u_host_ctrl_model.cyc(1'b0, 12'h456, 16'hBEEF);
        pchk(14'h0800);
        unl(CMD_EXIT);
        pchk(14'h0100);
        unl(CMD_BUFFER);
        w(12'h010, 8'h01);
        w(12'h011, 8'h11);
        w(12'h012, 8'h22);
        pchk(14'h0400);
        w(12'h000, CMD_CONFIRM);
        pchk(14'h0200);
        w(12'h000, CMD_EXIT);
        unl(CMD_PASSWORD);
        w(12'h000, CMD_BUFFER);
        w(12'h000, CMD_PW_KEY);
        for (int i = 0; i < 4; i++)
            u_host_ctrl_model.cyc(1'b0, i[11:0], {4{i[3:0]}});
        w(12'h000, CMD_CONFIRM);
        pchk(14'h0080);
        w(12'h000, CMD_EXIT);
        unl(CMD_PERSIST);
        w(12'h000, CMD_ERASE_SETUP);
        w(ADDR_000, CMD_ERASE_GO);
        pchk(14'h0040);
        w(12'h000, CMD_EXIT);
        unl(CMD_VOLATILE);
        w(12'h000, CMD_STATUS);
        u_host_ctrl_model.cyc(1'b1, 12'h5C0, 16'h0);
        pchk(14'h0001);
        cmp_v("rdata", 16'hC03C, rd_seen);
        w(12'h000, CMD_EXIT);
        unl(CMD_ECC);
        w(12'h9E1, CMD_ECC_CLEAR);
        pchk(14'h0020);
        w(12'h000, CMD_EXIT);
        unl(CMD_ARR_CRC);
        w(12'h800, CMD_CRC_START);
        w(12'h800, CMD_CRC_END);
        pchk(14'h0018);
        crc_busy = 1'b1;
        w(12'h000, CMD_CRC_SUSP);
        pchk(14'h0004);
        w(12'h000, CMD_CRC_RES);
        pchk(14'h0002);
        crc_busy = 1'b0;
    endtask
    initial begin
        rst_n = 1'b0;
        crc_busy = 1'b0;
        seen = 14'h0;
        rd_seen = 16'h0;
        errors = 0;
        total_checks = 0;
        cycles = 0;
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        cmp_ov(OV_NONE);
        sc_ident();
        sc_entry();
        sc_ops();
        end_of_test();
    end
endmodule // flash_overlay_command_decoder_tb

// >>> tb/host_ctrl_model.sv
// Host controller model: one framed bus cycle per call
module host_ctrl_model
    import cmd_decode_pkg::*;
(
    input  wire logic        SYS_CLK,
    output logic             CS_N,
    output logic             CYCLE_STROBE,
    output logic      [47:0] CA,
    output logic      [15:0] WDATA
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        CS_N = 1'b1;
        CYCLE_STROBE = 1'b0;
        CA = 48'h0;
        WDATA = 16'h0;
    end
    // Released lines show the inverse of the last value
    task automatic cyc(input logic rd, input logic [11:0] a,
                       input logic [15:0] d);
        @(posedge SYS_CLK);
        #1 CS_N = 1'b0;
        CA = {rd ? CA_TOP_READ : CA_TOP_WRITE, DIE_SELECT_VAL,
              31'h00000123, a};
        WDATA = d;
        CYCLE_STROBE = 1'b1;
        repeat (4) @(posedge SYS_CLK);
        #1 CYCLE_STROBE = 1'b0;
        CS_N = 1'b1;
        CA = ~CA;
        WDATA = ~WDATA;
        repeat (6) @(posedge SYS_CLK);
        #1;
    endtask
endmodule // host_ctrl_model
